// [design/adc_mode_consts.svh]
// Contract
// - One register bit picks internal or external reference operation.
// - External reference: common-level pin becomes input, references derived from it.
// - Gain settable 0 to 6 dB in 0.5 dB steps; full scale shrinks.
// - Gain resets to 0 dB, the 2 Vpp full-scale span.
// - Offset enable set: estimate each channel offset, subtract it every cycle.
// - Correction cancels at most plus or minus 10 mV of offset.
// - Enable cleared: estimate frozen, last correction still applied every cycle.
// - Offset correction disabled after reset.
// - Time-constant code 0 gives 256k cycles, doubling per step to code 11.
// - Mode 0 normal, 9/10/11 disable output buffers of B, A, both.
// - Mode 12 powers everything down, outputs high impedance, 30 us wake.
// - Mode 13 standby B, 14 standby A; references stay, 1 us wake.
// - Mode 15 interleaves both channels onto the first channel bus.
// - Multiplexed mode puts second channel pins in high impedance.
// - Pins give low three mode bits; top bit is OR of pins.
// - Sample clock below 1 MSPS forces a low-power state automatically.
`ifndef ADC_MODE_CONSTS_SVH
`define ADC_MODE_CONSTS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define REG_CTRL      8'h00
`define REG_TIMECONST 8'h04
`define REG_PMODE     8'h08
`define REG_STATUS    8'h0C
`define REG_OFS_A     8'h10
`define REG_OFS_B     8'h14

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define CTRL_REF_EXT  0
`define CTRL_OFS_EN   1
`define CTRL_PIN_SEL  2
`define CTRL_GAIN_LO  4
`define CTRL_GAIN_HI  7
`define GAIN_RESET    4'h0
`define GAIN_MAX      4'hC
`define TC_RESET      4'h0
`define TC_MAX        4'hB
`define TC_BASE_SHIFT 6'h12
`define PMODE_RESET   4'h0

// ----------------------------------------------------------------
// Datapath limits
// ----------------------------------------------------------------
`define OFS_LIMIT     15'sh0051
`define SAMPLE_MAX    15'sh1FFF
`define SAMPLE_MIN    -15'sh2000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ       50
`define GPD_WAKE_NS   30000
`define SB_WAKE_NS    1000
`define MIN_RATE_NS   1000
`define GPD_WAKE_CYC  11'((`GPD_WAKE_NS * `CLK_MHZ + 999) / 1000)
`define SB_WAKE_CYC   11'((`SB_WAKE_NS * `CLK_MHZ + 999) / 1000)
`define STOP_GAP_CYC  7'((`MIN_RATE_NS * `CLK_MHZ) / 1000)

`endif

// [design/adc_mode_pkg.sv]
package adc_mode_pkg;

  // Power-mode codes
  typedef enum logic [3:0] {
    PM_NORMAL  = 4'b0000,
    PM_DIS_B   = 4'b1001,
    PM_DIS_A   = 4'b1010,
    PM_DIS_AB  = 4'b1011,
    PM_GLOBAL  = 4'b1100,
    PM_STBY_B  = 4'b1101,
    PM_STBY_A  = 4'b1110,
    PM_MUX     = 4'b1111
  } pmode_e;

  // Bus slave phases
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_DATA = 2'b01
  } bus_state_e;

  typedef logic signed [13:0] sample_t;

endpackage

// [design/ofs_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface ofs_if;
  logic                    en;
  logic [3:0]              tc;
  adc_mode_pkg::sample_t   x;
  adc_mode_pkg::sample_t   y;
  logic signed [14:0]      est;
  modport core (input en, input tc, input x, output y, output est);
  modport ctrl (output en, output tc, output x, input y, input est);
endinterface
`default_nettype wire

// [design/pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Asynchronous pins and their settled copy
  input  wire logic [WIDTH-1:0] pin,
  output var  logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // Three stages; a level is taken once stages two and three agree
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        s1_q[i]  <= 1'b0;
        s2_q[i]  <= 1'b0;
        s3_q[i]  <= 1'b0;
        level[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          level[i] <= s3_q[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// [design/offset_channel.sv]
`timescale 1ns/1ns
`default_nettype none
`include "adc_mode_consts.svh"
module offset_channel (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Sample, control and corrected result
  ofs_if.core       ch
);
  logic signed [45:0] acc_q;
  logic signed [45:0] acc_d;
  logic signed [45:0] est_full;
  logic signed [14:0] est_lim;
  logic signed [14:0] err;
  logic signed [14:0] diff;
  logic [5:0]         shift;
  logic [3:0]         tc_eff;

  // Loop gain from time constant; reserved codes clamp to longest
  assign tc_eff   = (ch.tc > `TC_MAX) ? `TC_MAX : ch.tc;
  assign shift    = `TC_BASE_SHIFT + {2'b00, tc_eff};
  assign est_full = acc_q >>> shift;
  // Correction clamped to the cancel range
  assign est_lim  = (est_full > 46'(`OFS_LIMIT))  ? `OFS_LIMIT :
                    (est_full < -46'(`OFS_LIMIT)) ? -`OFS_LIMIT :
                    est_full[14:0];
  assign err      = 15'(ch.x) - est_lim;
  assign acc_d    = ch.en ? acc_q + 46'(err) : acc_q;
  assign diff     = 15'(ch.x) - est_lim;
  assign ch.est   = est_lim;

  // Integrator and corrected output, correction applied every cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_q <= '0;
      ch.y  <= '0;
    end else begin
      acc_q <= acc_d;
      ch.y  <= (diff > `SAMPLE_MAX) ? 14'sh1FFF :
               (diff < `SAMPLE_MIN) ? -14'sh2000 : diff[13:0];
    end
  end
endmodule
`default_nettype wire

// [design/adc_mode_ctrl.sv]
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "adc_mode_consts.svh"
module adc_mode_ctrl (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  // Control pins and sample clock pin
  input  wire logic        sleep_pin_one,
  input  wire logic        sleep_pin_two,
  input  wire logic        sleep_pin_three,
  input  wire logic        sample_clk_pin,
  // Raw converter samples
  input  wire logic [13:0] sample_a,
  input  wire logic [13:0] sample_b,
  // Output buses
  output var  logic [13:0] first_channel_bus,
  output var  logic        first_channel_oe_n,
  output var  logic [13:0] second_channel_bus,
  output var  logic        second_channel_oe_n,
  output var  logic        mux_second_tag,
  // Reference and gain
  output var  logic        common_level_oe_n,
  output var  logic        ref_from_common,
  output var  logic [3:0]  gain_code,
  // Power state
  output var  logic        conv_a_on,
  output var  logic        conv_b_on,
  output var  logic        ref_on,
  output var  logic        low_power,
  output var  logic        data_valid
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Undefined codes fall back to normal operation
  function automatic adc_mode_pkg::pmode_e legal_mode(input logic [3:0] c);
    adc_mode_pkg::pmode_e m;
    m = adc_mode_pkg::PM_NORMAL;
    if (c[3] && (c[2:0] != 3'b000)) begin
      m = adc_mode_pkg::pmode_e'(c);
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pins_s;

  pin_sync #(.WIDTH(4)) u_sync (
    .clock (clock),
    .rst   (rst),
    .pin   ({sample_clk_pin, sleep_pin_one, sleep_pin_two, sleep_pin_three}),
    .level (pins_s)
  );

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic                     ref_ext_q;
  logic                     ofs_en_q;
  logic                     pin_sel_q;
  logic [3:0]               gain_q;
  logic [3:0]               tc_q;
  logic [3:0]               pmode_q;
  adc_mode_pkg::bus_state_e bus_q;
  logic [7:0]               addr_q;
  logic                     write_q;
  logic                     clk_stop_q;
  logic                     valid_q;
  logic                     phase_q;
  logic [3:0]               gain_wr;
  logic                     take;
  logic                     wr_now;
  logic [31:0]              rdata;
  logic [3:0]               pin_code;
  logic [3:0]               mode_raw;
  adc_mode_pkg::pmode_e     mode;

  // Address phase taken on a selected non-idle transfer
  assign take    = hsel && htrans[1] && hready;
  assign wr_now  = (bus_q == adc_mode_pkg::BUS_DATA) && write_q;
  // Gain beyond 6 dB clamps to the top step
  assign gain_wr = (hwdata[`CTRL_GAIN_HI:`CTRL_GAIN_LO] > `GAIN_MAX) ?
                   `GAIN_MAX : hwdata[`CTRL_GAIN_HI:`CTRL_GAIN_LO];

  // Pins give low bits, top bit is any pin high
  assign pin_code = {|pins_s[2:0], pins_s[2:0]};
  // Pins override the register copy while selected
  assign mode_raw = pin_sel_q ? pin_code : pmode_q;
  assign mode     = legal_mode(mode_raw);

  ofs_if ofs_a ();
  ofs_if ofs_b ();

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (addr_q)
      `REG_CTRL:      rdata = {24'h00_0000, gain_q, 1'b0, pin_sel_q, ofs_en_q, ref_ext_q};
      `REG_TIMECONST: rdata = {28'h000_0000, tc_q};
      `REG_PMODE:     rdata = {28'h000_0000, pmode_q};
      `REG_STATUS:    rdata = {23'h00_0000, conv_b_on, conv_a_on, ref_on, valid_q, clk_stop_q, mode};
      `REG_OFS_A:     rdata = 32'(ofs_a.est);
      `REG_OFS_B:     rdata = 32'(ofs_b.est);
      default:        rdata = 32'h0000_0000;
    endcase
  end

  // Bus phases: one wait state, then write stored or read returned
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_q     <= adc_mode_pkg::BUS_IDLE;
      addr_q    <= 8'h00;
      write_q   <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      unique case (bus_q)
        adc_mode_pkg::BUS_IDLE: begin
          if (take) begin
            bus_q     <= adc_mode_pkg::BUS_DATA;
            addr_q    <= haddr[7:0];
            write_q   <= hwrite;
            hreadyout <= 1'b0;
          end
        end
        adc_mode_pkg::BUS_DATA: begin
          bus_q     <= adc_mode_pkg::BUS_IDLE;
          hreadyout <= 1'b1;
          if (!write_q) begin
            hrdata <= rdata;
          end
        end
      endcase
    end
  end

  // Register writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ref_ext_q <= 1'b0;
      ofs_en_q  <= 1'b0;
      pin_sel_q <= 1'b0;
      gain_q    <= `GAIN_RESET;
      tc_q      <= `TC_RESET;
      pmode_q   <= `PMODE_RESET;
    end else if (wr_now) begin
      if (addr_q == `REG_CTRL) begin
        ref_ext_q <= hwdata[`CTRL_REF_EXT];
        ofs_en_q  <= hwdata[`CTRL_OFS_EN];
        pin_sel_q <= hwdata[`CTRL_PIN_SEL];
        gain_q    <= gain_wr;
      end
      if (addr_q == `REG_TIMECONST) begin
        tc_q <= hwdata[3:0];
      end
      if (addr_q == `REG_PMODE) begin
        pmode_q <= hwdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Offset correction channels
  // ----------------------------------------------------------------
  assign ofs_a.en = ofs_en_q;
  assign ofs_a.tc = tc_q;
  assign ofs_a.x  = adc_mode_pkg::sample_t'(sample_a);
  assign ofs_b.en = ofs_en_q;
  assign ofs_b.tc = tc_q;
  assign ofs_b.x  = adc_mode_pkg::sample_t'(sample_b);

  offset_channel u_ofs_a (
    .clock (clock),
    .rst   (rst),
    .ch    (ofs_a.core)
  );

  offset_channel u_ofs_b (
    .clock (clock),
    .rst   (rst),
    .ch    (ofs_b.core)
  );

  // ----------------------------------------------------------------
  // Sample clock stop detection
  // ----------------------------------------------------------------
  logic [6:0] gap_q;
  logic       sclk_prev_q;
  logic       sclk_rise;
  logic       clk_stop;

  // Rising edge of the settled sample clock copy
  assign sclk_rise = pins_s[3] && !sclk_prev_q;
  // No edge for a full slow period means the rate is under the floor
  assign clk_stop  = gap_q >= `STOP_GAP_CYC;

  // Cycles since the last sample clock edge, saturating
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_prev_q <= 1'b0;
      gap_q       <= `STOP_GAP_CYC;
    end else begin
      sclk_prev_q <= pins_s[3];
      if (sclk_rise) begin
        gap_q <= 7'h00;
      end else if (!clk_stop) begin
        gap_q <= gap_q + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power state and wake timing
  // ----------------------------------------------------------------
  logic        gpd;
  logic        stby_a;
  logic        stby_b;
  logic        dis_a;
  logic        dis_b;
  logic        mux;
  logic [10:0] wake_q;
  logic [10:0] wake_d;
  logic        a_run;
  logic        b_run;
  logic        down_any;
  logic        wake_done;

  assign gpd    = (mode == adc_mode_pkg::PM_GLOBAL);
  assign stby_a = (mode == adc_mode_pkg::PM_STBY_A);
  assign stby_b = (mode == adc_mode_pkg::PM_STBY_B);
  assign dis_a  = (mode == adc_mode_pkg::PM_DIS_A) || (mode == adc_mode_pkg::PM_DIS_AB);
  assign dis_b  = (mode == adc_mode_pkg::PM_DIS_B) || (mode == adc_mode_pkg::PM_DIS_AB);
  assign mux    = (mode == adc_mode_pkg::PM_MUX);
  assign a_run  = !(gpd || stby_a || clk_stop);
  assign b_run  = !(gpd || stby_b || clk_stop);

  // Standby or a stopped sample clock keeps at least the short wake
  assign down_any = stby_a || stby_b || clk_stop;

  // Reload wake time while down; global down needs the long wake
  assign wake_d = gpd ? `GPD_WAKE_CYC :
                  (down_any && (wake_q < `SB_WAKE_CYC)) ? `SB_WAKE_CYC :
                  (wake_q != 11'h000) ? wake_q - 11'h001 : 11'h000;
  assign wake_done = (wake_d == 11'h000);

  // Power controls and valid flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_q     <= `GPD_WAKE_CYC;
      valid_q    <= 1'b0;
      clk_stop_q <= 1'b1;
      conv_a_on  <= 1'b0;
      conv_b_on  <= 1'b0;
      ref_on     <= 1'b0;
      low_power  <= 1'b1;
      data_valid <= 1'b0;
    end else begin
      wake_q     <= wake_d;
      valid_q    <= wake_done;
      clk_stop_q <= clk_stop;
      conv_a_on  <= a_run;
      conv_b_on  <= b_run;
      ref_on     <= !gpd;
      low_power  <= clk_stop || gpd;
      data_valid <= wake_done;
    end
  end

  // ----------------------------------------------------------------
  // Reference and gain outputs
  // ----------------------------------------------------------------
  // External mode releases the common-level pin to act as input
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      common_level_oe_n <= 1'b0;
      ref_from_common   <= 1'b0;
      gain_code         <= `GAIN_RESET;
    end else begin
      common_level_oe_n <= ref_ext_q;
      ref_from_common   <= ref_ext_q;
      gain_code         <= gain_q;
    end
  end

  // ----------------------------------------------------------------
  // Output buses
  // ----------------------------------------------------------------
  logic [13:0] a_word;
  logic [13:0] b_word;
  logic        phase_d;
  logic [13:0] first_d;
  logic [13:0] second_d;
  logic        oe_a_n_d;
  logic        oe_b_n_d;
  logic        tag_d;

  assign a_word = (valid_q && a_run) ? 14'(ofs_a.y) : 14'h0000;
  assign b_word = (valid_q && b_run) ? 14'(ofs_b.y) : 14'h0000;

  // Interleave and buffer-enable selection
  assign phase_d  = mux ? !phase_q : 1'b0;
  assign first_d  = (mux && phase_q) ? b_word : a_word;
  assign second_d = mux ? 14'h0000 : b_word;
  assign oe_a_n_d = gpd || dis_a;
  assign oe_b_n_d = gpd || dis_b || mux;
  assign tag_d    = mux && phase_q;

  // Drive, disable and interleave the buses
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_q             <= 1'b0;
      first_channel_bus   <= 14'h0000;
      second_channel_bus  <= 14'h0000;
      first_channel_oe_n  <= 1'b1;
      second_channel_oe_n <= 1'b1;
      mux_second_tag      <= 1'b0;
    end else begin
      phase_q             <= phase_d;
      first_channel_bus   <= first_d;
      second_channel_bus  <= second_d;
      first_channel_oe_n  <= oe_a_n_d;
      second_channel_oe_n <= oe_b_n_d;
      mux_second_tag      <= tag_d;
    end
  end

endmodule
`default_nettype wire

// [tb/adc_mode_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module adc_mode_checker (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Bus handshake
  input  wire logic        hsel,
  input  wire logic [1:0]  htrans,
  input  wire logic        hready,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  // Pins and outputs
  input  wire logic        sample_clk_pin,
  input  wire logic [13:0] first_channel_bus,
  input  wire logic        first_channel_oe_n,
  input  wire logic [13:0] second_channel_bus,
  input  wire logic        second_channel_oe_n,
  input  wire logic        mux_second_tag,
  input  wire logic        common_level_oe_n,
  input  wire logic        ref_from_common,
  input  wire logic [3:0]  gain_code,
  input  wire logic        ref_on,
  input  wire logic        low_power,
  input  wire logic        data_valid
);
  logic       pin_q;
  logic [6:0] stop_q;
  logic [5:0] low_q;

  // --------
  // Idle time of the sample pin and length of each invalid spell
  // --------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_q  <= 1'b0;
      stop_q <= 7'h00;
      low_q  <= 6'h00;
    end else begin
      pin_q  <= sample_clk_pin;
      stop_q <= (sample_clk_pin != pin_q) ? 7'h00 : stop_q + {6'h00, stop_q != 7'h7F};
      low_q  <= data_valid ? 6'h00 : low_q + {5'h00, low_q != 6'h3F};
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Bus answers, references, gain and power behaviour
  bus_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  bus_wait_a: assert property (hsel && htrans[1] && hready && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state wrong");
  ref_input_a: assert property (ref_from_common |-> common_level_oe_n)
    else $error("common level pin driven in external mode");
  gain_range_a: assert property (gain_code <= 4'hC)
    else $error("gain above six decibels");
  down_hiz_a: assert property ($fell(ref_on) |-> ##[0:2] (first_channel_oe_n && second_channel_oe_n))
    else $error("buses driven in global power down");
  wake_floor_a: assert property ($rose(data_valid) |-> low_q >= 6'd49)
    else $error("data valid too soon after wake");
  mux_hiz_a: assert property ($rose(mux_second_tag) |-> second_channel_oe_n && second_channel_bus == 14'h0000)
    else $error("second bus driven in mux mode");
  mux_alt_a: assert property (mux_second_tag |=> !mux_second_tag)
    else $error("mux samples not interleaved");
  clock_stop_a: assert property (stop_q == 7'd70 |-> low_power)
    else $error("no low power with sample clock stopped");
  invalid_zero_a: assert property (!data_valid [*2] |-> first_channel_bus == 14'h0000 && second_channel_bus == 14'h0000)
    else $error("bus not zero while data invalid");
endmodule

bind adc_mode_ctrl adc_mode_checker chk (
  .clock(clock), .rst(rst), .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .sample_clk_pin(sample_clk_pin), .first_channel_bus(first_channel_bus),
  .first_channel_oe_n(first_channel_oe_n), .second_channel_bus(second_channel_bus),
  .second_channel_oe_n(second_channel_oe_n), .mux_second_tag(mux_second_tag),
  .common_level_oe_n(common_level_oe_n), .ref_from_common(ref_from_common), .gain_code(gain_code),
  .ref_on(ref_on), .low_power(low_power), .data_valid(data_valid)
);
`default_nettype wire

// [tb/host_model.sv]
`timescale 1ns/1ns
`default_nettype none
`include "adc_mode_consts.svh"
module host_model (
  // Clock
  input  wire logic        clock,
  // Bus master side
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // --------
  // Host configuration master
  // --------
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // One single word transfer, holding each phase until hready
  task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr_en;
    do @(posedge clock); while (!hready);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (!hready);
    q = hrdata;
  endtask

  // Reserved time-constant codes are never sent
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, (a == `REG_TIMECONST && d[3:0] > `TC_MAX) ? 32'(`TC_MAX) : d, q);
  endtask

  // Register read
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask
endmodule
`default_nettype wire

// [tb/dual_adc_mode_control_bench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "adc_mode_consts.svh"
module dual_adc_mode_control_bench;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [2:0]  pins = 3'h0;
  logic        smp_clk = 1'b0;
  logic        smp_run = 1'b1;
  logic [13:0] sa = 14'h0000;
  logic [13:0] sb = 14'h0000;
  logic [13:0] bus_a;
  logic [13:0] bus_b;
  logic        oe_a_n;
  logic        oe_b_n;
  logic        tag;
  logic        cl_oe_n;
  logic        ref_cm;
  logic [3:0]  gain;
  logic        on_a;
  logic        on_b;
  logic        on_ref;
  logic        lp;
  logic        valid;
  logic [31:0] q;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;

  // --------
  // Clock, sample pin and hang guard
  // --------
  initial begin
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (smp_run && cyc % 4 == 0) smp_clk <= ~smp_clk;
    if (cyc == 40000) begin
      n_fail++;
      complete_run();
    end
  end

  // Host and device
  host_model host (.clock(clock), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
  adc_mode_ctrl dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .sleep_pin_one(pins[2]), .sleep_pin_two(pins[1]),
    .sleep_pin_three(pins[0]), .sample_clk_pin(smp_clk), .sample_a(sa), .sample_b(sb),
    .first_channel_bus(bus_a), .first_channel_oe_n(oe_a_n), .second_channel_bus(bus_b),
    .second_channel_oe_n(oe_b_n), .mux_second_tag(tag), .common_level_oe_n(cl_oe_n),
    .ref_from_common(ref_cm), .gain_code(gain), .conv_a_on(on_a), .conv_b_on(on_b),
    .ref_on(on_ref), .low_power(lp), .data_valid(valid));

  // Comparison, waits and expected power outputs
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask

  function automatic logic [4:0] pm_exp(input logic [3:0] m);
    case (m)
      4'h9: return 5'h0F;
      4'hA: return 5'h17;
      4'hB: return 5'h1F;
      4'hC: return 5'h18;
      4'hD: return 5'h05;
      4'hE: return 5'h03;
      4'hF: return 5'h0F;
      default: return 5'h07;
    endcase
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_reset();
    check({gain, lp, valid}, 6'h02);
    check({hresp, hready}, 2'h1);
    host.rd(`REG_CTRL, q);
    check(q, 32'h0000_0000);
    host.rd(`REG_OFS_A, q);
    check(q, 32'h0000_0000);
    host.wr(8'h20, 32'hFFFF_FFFF);
    host.rd(8'h20, q);
    check(q, 32'h0000_0000);
  endtask

  task automatic t_gain_ref();
    host.wr(`REG_CTRL, 32'h0000_00C0);
    wt(2);
    check(gain, `GAIN_MAX);
    host.wr(`REG_CTRL, 32'h0000_00F0);
    wt(2);
    check(gain, `GAIN_MAX);
    host.wr(`REG_CTRL, 32'h0000_0051);
    host.rd(`REG_CTRL, q);
    check(q, 32'h0000_0051);
    check({gain, ref_cm, cl_oe_n}, 6'h17);
    host.wr(`REG_CTRL, 32'h0000_0000);
    wt(2);
    check({gain, ref_cm, cl_oe_n}, 6'h00);
  endtask

  task automatic t_modes();
    for (int m = 0; m < 16; m++) begin
      host.wr(`REG_PMODE, 32'(m));
      wt(6);
      check({oe_a_n, oe_b_n, on_a, on_b, on_ref}, pm_exp(4'(m)));
    end
  endtask

  task automatic t_pins();
    host.wr(`REG_CTRL, 32'h0000_0004);
    for (int p = 0; p < 8; p++) begin
      pins <= 3'(p);
      wt(10);
      host.rd(`REG_STATUS, q);
      check(q[3:0], {|pins, pins});
      check({oe_a_n, oe_b_n, on_a, on_b, on_ref}, pm_exp({|pins, pins}));
    end
    pins <= 3'h0;
    host.wr(`REG_CTRL, 32'h0000_0000);
  endtask

  task automatic t_wake();
    host.wr(`REG_PMODE, 32'h0000_000C);
    wt(10);
    check({lp, valid}, 2'h2);
    host.wr(`REG_PMODE, 32'h0000_0000);
    wt(1400);
    check(valid, 1'b0);
    for (int i = 0; i < 300 && valid !== 1'b1; i++) wt(1);
    check({lp, valid}, 2'h1);
  endtask

  task automatic t_stop();
    smp_run <= 1'b0;
    wt(80);
    check(lp, 1'b1);
    smp_run <= 1'b1;
    for (int i = 0; i < 200 && valid !== 1'b1; i++) wt(1);
    check({lp, valid}, 2'h1);
  endtask

  task automatic t_offset();
    sa <= 14'h1F40;
    sb <= 14'h20C0;
    host.wr(`REG_TIMECONST, 32'h0000_000B);
    host.rd(`REG_TIMECONST, q);
    check(q, 32'h0000_000B);
    host.wr(`REG_CTRL, 32'h0000_0002);
    wt(2000);
    host.rd(`REG_OFS_A, q);
    check(q, 32'h0000_0000);
    host.wr(`REG_TIMECONST, 32'h0000_0000);
    wt(8000);
    host.rd(`REG_OFS_A, q);
    check(q, 32'h0000_0051);
    host.rd(`REG_OFS_B, q);
    check(q, 32'hFFFF_FFAF);
    check({bus_a, bus_b}, {14'h1EEF, 14'h2111});
    host.wr(`REG_CTRL, 32'h0000_0000);
    sa <= 14'h1FA4;
    wt(2000);
    check(bus_a, 14'h1F53);
    host.rd(`REG_OFS_A, q);
    check(q, 32'h0000_0051);
  endtask

  task automatic t_mux();
    host.wr(`REG_PMODE, 32'h0000_000F);
    for (int i = 0; i < 20 && tag !== 1'b1; i++) wt(1);
    check({tag, bus_a, bus_b, oe_b_n}, {1'b1, 14'h2111, 14'h0000, 1'b1});
    wt(1);
    check({tag, bus_a}, {1'b0, 14'h1F53});
    host.wr(`REG_PMODE, 32'h0000_0000);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_gain_ref();
    t_modes();
    t_pins();
    t_wake();
    t_stop();
    t_offset();
    t_mux();
    complete_run();
  end
endmodule
`default_nettype wire
